// ===== logic/srw_pkg.sv
// constants and types for the supervisor reset and watchdog block
// Operation
// - each trigger drives reset low 200ms
// - hold reset 200ms after every release event
// - manual reset low asserts reset continuously
// - manual reset high: hold further 200ms
// - high reset output inverts low output
// - idle kick beyond timeout triggers reset
// - reset or kick edge clears watchdog timer
// - floating kick input never causes reset
// - manual reset input pulled high internally
// - watchdog timeout nominally 1.6 seconds
// - watchdog held cleared while reset asserted
// - kick pulses of 50ns are detected
// - supply dip restarts hold timer
package srw_pkg;

    localparam int unsigned CLK_FREQ_HZ      = 25_000_000;
    localparam int unsigned RESET_HOLD_MS    = 200;
    // 1.6 s watchdog timeout, kept in milliseconds
    localparam int unsigned WD_TIMEOUT_MS    = 1600;
    localparam int unsigned KICK_MIN_NS      = 50;
    localparam int unsigned CLK_PER_MS       = CLK_FREQ_HZ / 1000;
    localparam int unsigned RESET_HOLD_CYC   = CLK_PER_MS * RESET_HOLD_MS;
    localparam int unsigned WD_TIMEOUT_CYC   = CLK_PER_MS * WD_TIMEOUT_MS;
    // internal kick driver goes high for the last eighth of the timeout
    localparam int unsigned KICK_DRV_NUM     = 7;
    localparam int unsigned KICK_DRV_DEN     = 8;
    localparam logic        RESET_N_RST      = 1'b0;
    localparam logic        RESET_HI_RST     = 1'b1;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_ASSERT = 2'b01,
        ST_HOLD   = 2'b11
    } srw_state_t;

endpackage

// ===== logic/srw_tmr_if.sv
// timer control and status carried between the supervisor and its counters
`timescale 1ns/1ps
interface srw_tmr_if #(
    parameter int CNT_W = 8
);
    logic             clear;
    logic             run;
    logic [CNT_W-1:0] count;
    logic             expired;

    modport timer (input clear, input run, output count, output expired);
    modport ctrl  (output clear, output run, input count, input expired);
endinterface

// ===== logic/srw_timer.sv
// saturating period counter with clear and run controls
`timescale 1ns/1ps
module srw_timer
    import srw_pkg::*;
#(
    parameter int          CNT_W = 8,
    parameter int unsigned TERM  = 100
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // control and status
    srw_tmr_if.timer  t
);
    localparam logic [CNT_W-1:0] TERM_C = CNT_W'(TERM);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    wire              at_term = (count_reg == TERM_C);

    // clear has priority; counter stops at the terminal count
    assign count_next = t.clear ? '0 :
                        (t.run && !at_term) ? count_reg + CNT_W'(1) : count_reg;
    assign t.count    = count_reg;
    assign t.expired  = at_term;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    chk_timer_clear: assert property (@(posedge clock) disable iff (!rstn)
        t.clear |=> (count_reg == '0)) else $error("timer not cleared");
    chk_timer_step: assert property (@(posedge clock) disable iff (!rstn)
        (!t.clear && t.run && !at_term) |=> (count_reg == $past(count_reg) + CNT_W'(1)))
        else $error("timer did not advance");
endmodule

// ===== logic/srw_supervisor.sv
// supervisor: reset generation, reset-hold stretch and watchdog
`timescale 1ns/1ps
module srw_supervisor
    import srw_pkg::*;
#(
    parameter int unsigned HOLD_CYC = RESET_HOLD_CYC,
    parameter int unsigned WD_CYC   = WD_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // supply comparator
    input  wire logic supply_low,
    // manual reset pin
    input  wire logic manual_reset_n,
    output wire logic manual_reset_pu_out,
    output wire logic manual_reset_pu_oe,
    // watchdog kick pin
    input  wire logic watchdog_kick_input,
    output wire logic watchdog_kick_out,
    output wire logic watchdog_kick_oe,
    // reset outputs toward the host
    output wire logic reset_n_out,
    output wire logic reset_out
);
    localparam int HOLD_W = $clog2(HOLD_CYC + 1);
    localparam int WD_W   = $clog2(WD_CYC + 1);
    // point at which the internal kick driver turns high
    localparam logic [WD_W-1:0] KICK_DRV_AT =
        WD_W'((64'(WD_CYC) * KICK_DRV_NUM) / KICK_DRV_DEN);

    srw_tmr_if #(.CNT_W(HOLD_W)) hold_t ();
    srw_tmr_if #(.CNT_W(WD_W))   wd_t ();

    srw_state_t state_reg;
    srw_state_t state_next;
    logic       supply_meta_reg;
    logic       supply_sync_reg;
    logic       kick_last_reg;
    logic       kick_drive_reg;
    logic       reset_n_reg;
    logic       reset_hi_reg;

    // the comparator output is asynchronous to our clock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            supply_meta_reg <= 1'b1;
            supply_sync_reg <= 1'b1;
        end else begin
            supply_meta_reg <= supply_low;
            supply_sync_reg <= supply_meta_reg;
        end
    end

    // level causes: held reset for as long as either stands
    wire level_cause = supply_sync_reg || !manual_reset_n;
    // every sampled level change is an edge; one 40 ns sample catches a 50 ns pulse
    wire kick_edge   = watchdog_kick_input ^ kick_last_reg;
    wire in_run      = (state_reg == ST_RUN);
    wire wd_fire     = in_run && wd_t.expired;

    // gray path run -> assert -> hold -> run; watchdog expiry jumps to hold
    // a three-state loop cannot stay gray throughout: hold to run flips both bits
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN: begin
                if (level_cause) begin
                    state_next = ST_ASSERT;
                end else if (wd_fire) begin
                    state_next = ST_HOLD;
                end
            end
            ST_ASSERT: begin
                if (!level_cause) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (level_cause) begin
                    state_next = ST_ASSERT;
                end else if (hold_t.expired) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_ASSERT;
            end
        endcase
    end

    // hold timer counts only while stretching; any other state restarts it
    assign hold_t.clear = (state_reg != ST_HOLD);
    assign hold_t.run   = (state_reg == ST_HOLD);

    // watchdog cleared throughout reset and on every kick edge
    assign wd_t.clear   = !in_run || kick_edge;
    assign wd_t.run     = in_run;

    // driver forced low whenever reset follows, so it never shows a stale late-count high
    wire kick_drive_next = (state_next == ST_RUN) && (wd_t.count >= KICK_DRV_AT);

    // both periods use the same saturating timer

    srw_timer #(.CNT_W(HOLD_W), .TERM(HOLD_CYC)) u_hold (
        .clock (clock),
        .rstn  (rstn),
        .t     (hold_t)
    );

    srw_timer #(.CNT_W(WD_W), .TERM(WD_CYC)) u_wd (
        .clock (clock),
        .rstn  (rstn),
        .t     (wd_t)
    );

    // power-up starts in hold so the host gets a full reset pulse
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg      <= ST_HOLD;
            kick_last_reg  <= 1'b0;
            kick_drive_reg <= 1'b0;
            reset_n_reg    <= RESET_N_RST;
            reset_hi_reg   <= RESET_HI_RST;
        end else begin
            state_reg      <= state_next;
            kick_last_reg  <= watchdog_kick_input;
            kick_drive_reg <= kick_drive_next;
            reset_n_reg    <= (state_next == ST_RUN);
            reset_hi_reg   <= (state_next != ST_RUN);
        end
    end

    // weak internal driver: an open kick pin follows it and services the
    // timer before expiry; a stronger external driver simply overrides it
    assign watchdog_kick_out   = kick_drive_reg;
    assign watchdog_kick_oe    = 1'b1;

    // weak pull-up so an open manual reset pin reads inactive
    assign manual_reset_pu_out = 1'b1;
    assign manual_reset_pu_oe  = 1'b1;

    assign reset_n_out = reset_n_reg;
    assign reset_out   = reset_hi_reg;

    // helper: cycles spent in hold since entering it
    logic [HOLD_W:0] hold_age_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hold_age_reg <= '0;
        end else if (state_reg != ST_HOLD) begin
            hold_age_reg <= '0;
        end else if (hold_age_reg[HOLD_W] == 1'b0) begin
            hold_age_reg <= hold_age_reg + (HOLD_W + 1)'(1);
        end
    end

    chk_outputs_inverse: assert property (@(posedge clock) disable iff (!rstn)
        reset_out == !reset_n_out) else $error("reset outputs not inverse");

    chk_manual_asserts: assert property (@(posedge clock) disable iff (!rstn)
        !manual_reset_n |=> !reset_n_out) else $error("manual reset not asserted");

    chk_supply_asserts: assert property (@(posedge clock) disable iff (!rstn)
        supply_sync_reg |=> !reset_n_out) else $error("supply low not asserted");

    chk_hold_length: assert property (@(posedge clock) disable iff (!rstn)
        $rose(reset_n_reg) |-> ($past(hold_age_reg) == (HOLD_W + 1)'(HOLD_CYC)))
        else $error("reset hold length wrong");

    chk_manual_release: assert property (@(posedge clock) disable iff (!rstn)
        ($rose(manual_reset_n) && !supply_sync_reg) |=> (!reset_n_out && state_reg == ST_HOLD))
        else $error("manual release not stretched");

    chk_wd_cleared: assert property (@(posedge clock) disable iff (!rstn)
        (!in_run) |=> (wd_t.count == '0 || in_run)) else $error("watchdog counts in reset");

    chk_kick_clears: assert property (@(posedge clock) disable iff (!rstn)
        kick_edge |=> (wd_t.count == '0)) else $error("kick did not clear watchdog");

    chk_wd_fires: assert property (@(posedge clock) disable iff (!rstn)
        (wd_fire && !level_cause) |=> (state_reg == ST_HOLD && !reset_n_out))
        else $error("watchdog expiry lost");

    chk_drive_low_reset: assert property (@(posedge clock) disable iff (!rstn)
        (!in_run) [*2] |-> !watchdog_kick_out) else $error("kick driver high in reset");

    chk_supply_restart: assert property (@(posedge clock) disable iff (!rstn)
        (state_reg == ST_HOLD && level_cause) |=> (state_reg == ST_ASSERT) ##1 (hold_t.count == '0))
        else $error("hold timer not restarted");

    // release, stretch and watchdog timing as seen from the state register
    chk_state_outputs: assert property (@(posedge clock) disable iff (!rstn)
        reset_n_out == (state_reg == ST_RUN)) else $error("reset output disagrees with state");

    chk_hold_no_early: assert property (@(posedge clock) disable iff (!rstn)
        (state_reg == ST_HOLD && !hold_t.expired) |=> !reset_n_out)
        else $error("reset released before hold ended");

    chk_hold_releases: assert property (@(posedge clock) disable iff (!rstn)
        (state_reg == ST_HOLD && hold_t.expired && !level_cause) |=> reset_n_out)
        else $error("reset not released after hold");

    chk_assert_stays: assert property (@(posedge clock) disable iff (!rstn)
        (state_reg == ST_ASSERT && level_cause) |=> (state_reg == ST_ASSERT))
        else $error("reset left while cause stands");

    chk_wd_counts: assert property (@(posedge clock) disable iff (!rstn)
        (in_run && !kick_edge && !wd_t.expired) |=> (wd_t.count == $past(wd_t.count) + WD_W'(1)))
        else $error("watchdog not counting while released");

    chk_wd_no_early: assert property (@(posedge clock) disable iff (!rstn)
        (in_run && !wd_t.expired && !level_cause) |=> reset_n_out)
        else $error("watchdog reset before timeout");

    chk_drive_high: assert property (@(posedge clock) disable iff (!rstn)
        (in_run && wd_t.count >= KICK_DRV_AT && !level_cause && !wd_fire) |=> watchdog_kick_out)
        else $error("kick driver not high late in timeout");

    chk_drive_low_early: assert property (@(posedge clock) disable iff (!rstn)
        (wd_t.count < KICK_DRV_AT) |=> !watchdog_kick_out)
        else $error("kick driver high early in timeout");
endmodule

// ===== verif/srw_host_model.sv
// host side model: resolves the manual reset and watchdog kick pins
`timescale 1ns/1ps
module srw_host_model (
    // host controls
    input  wire logic man_drive,
    input  wire logic kick_en,
    input  wire logic kick_val,
    // device weak drivers
    input  wire logic pu_out,
    input  wire logic pu_oe,
    input  wire logic kick_out,
    input  wire logic kick_oe,
    // resolved pins
    output wire logic man_pin_n,
    output wire logic kick_w
);
    // strong host driver beats the weak pull-up; open pin reads high
    assign man_pin_n = man_drive ? 1'b0 : (pu_oe ? pu_out : 1'b1);
    // a released kick line shows only the internal driver
    assign kick_w    = kick_en ? kick_val : (kick_oe ? kick_out : 1'b0);
endmodule

// ===== verif/tb_srw_supervisor.sv
// testbench for the supervisor reset and watchdog block
`timescale 1ns/1ps
module tb_srw_supervisor;
    import srw_pkg::*;
    localparam int HOLD = 20;
    localparam int WD   = 64;
    typedef struct { bit cause; int len; logic exp_n; } srw_row_t;
    logic      clock      = 1'b0;
    logic      rstn       = 1'b0;
    logic      supply_low = 1'b0;
    logic      man_drive  = 1'b0;
    logic      kick_en    = 1'b0;
    logic      kick_val   = 1'b0;
    logic      saw_low    = 1'b0;
    wire logic man_pin_n, pu_out, pu_oe, kick_w, kick_out, kick_oe, reset_n_out, reset_out;
    int        n_fail     = 0;
    int        cmp_count  = 0;
    int        n;
    // cause 0 = manual pin, 1 = supply low; exp_n = reset_n_out while the cause stands
    srw_row_t  rows [4]   = '{'{0, 1, 1'b0}, '{0, 5, 1'b0}, '{1, 1, 1'b0}, '{1, 8, 1'b0}};

    always #20 clock = ~clock;

    srw_supervisor #(.HOLD_CYC(HOLD), .WD_CYC(WD)) uut (
        .clock(clock), .rstn(rstn), .supply_low(supply_low), .manual_reset_n(man_pin_n),
        .manual_reset_pu_out(pu_out), .manual_reset_pu_oe(pu_oe), .watchdog_kick_input(kick_w),
        .watchdog_kick_out(kick_out), .watchdog_kick_oe(kick_oe), .reset_n_out(reset_n_out),
        .reset_out(reset_out));

    srw_host_model host (
        .man_drive(man_drive), .kick_en(kick_en), .kick_val(kick_val), .pu_out(pu_out),
        .pu_oe(pu_oe), .kick_out(kick_out), .kick_oe(kick_oe), .man_pin_n(man_pin_n), .kick_w(kick_w));

    task automatic results();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(string name, logic exp, logic got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_range(string name, int k, int lo, int hi);
        cmp_count++;
        if (k < lo || k > hi) begin
            n_fail++;
            $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, k);
        end
    endtask

    task automatic step(int k);
        repeat (k) begin
            @(posedge clock);
            #1;
            if (reset_n_out === 1'b0) saw_low = 1'b1;
            check("reset_out", reset_n_out === 1'b0, reset_out);
        end
    endtask

    // cycles until the host is let out of reset
    task automatic hold_len(output int k);
        k = 0;
        while (reset_n_out !== 1'b1 && k < 500) begin
            step(1);
            k++;
        end
    endtask

    initial begin
        #(40 * 3000);
        n_fail++;
        results();
    end

    initial begin
        step(3);
        check("reset_n_out in reset", 1'b0, reset_n_out);
        check("manual pin open", 1'b1, man_pin_n);
        check("pull-up enable", 1'b1, pu_oe);
        check("kick driver enable", 1'b1, kick_oe);
        check("kick driver in reset", 1'b0, kick_out);
        rstn = 1'b1;
        hold_len(n);
        check_range("power-on hold", n, HOLD, HOLD + 4);
        foreach (rows[i]) begin
            if (rows[i].cause) supply_low = 1'b1;
            else man_drive = 1'b1;
            step(rows[i].len + 3);
            check("reset_n_out under cause", rows[i].exp_n, reset_n_out);
            supply_low = 1'b0;
            man_drive  = 1'b0;
            hold_len(n);
            check_range("hold after release", n, HOLD, HOLD + 4);
        end
        // a dip in mid-hold must start the stretch again
        supply_low = 1'b1;
        step(4);
        supply_low = 1'b0;
        step(HOLD / 2);
        supply_low = 1'b1;
        step(1);
        supply_low = 1'b0;
        hold_len(n);
        check_range("restart hold", n, HOLD, HOLD + 4);
        // host holds the kick pin low and never toggles it
        kick_en = 1'b1;
        n = 0;
        while (reset_n_out !== 1'b0 && n < 1000) begin
            step(1);
            n++;
        end
        check_range("watchdog expiry", n, WD - 4, WD + 4);
        hold_len(n);
        check_range("watchdog reset pulse", n, HOLD, HOLD + 4);
        // one-cycle pulses just inside the timeout keep the host alive
        saw_low = 1'b0;
        repeat (5) begin
            step(WD - 10);
            kick_val = 1'b1;
            step(1);
            kick_val = 1'b0;
        end
        check("reset while kicked", 1'b0, saw_low);
        kick_en = 1'b0;
        step(4 * WD);
        check("reset with open kick pin", 1'b0, saw_low);
        // second power-on reset in mid-run
        rstn = 1'b0;
        step(2);
        check("reset_n_out in second reset", 1'b0, reset_n_out);
        rstn = 1'b1;
        hold_len(n);
        check_range("second power-on hold", n, HOLD, HOLD + 4);
        results();
    end
endmodule
